// [acg_defines.svh]
// Register offsets, field positions and reset values for the channel gate control
// Assumes a register front end that decodes the serial bus into byte accesses
`ifndef ACG_DEFINES_SVH
`define ACG_DEFINES_SVH

`define ACG_ADDR_SKIP 8'h08
`define ACG_ADDR_TRIG 8'h09
`define ACG_ADDR_DEEP 8'h0A
`define ACG_SKIP_RESET 8'h00
`define ACG_DEEP_RESET 1'b0
`define ACG_TRIG_BIT 0
`define ACG_DEEP_BIT 0
`define ACG_MODE_2 2'h2
`define ACG_MODE_3 2'h3
`define ACG_WMASK_FULL 8'hFF
`define ACG_WMASK_M2 8'h8F
`define ACG_WMASK_M3 8'hBF

`endif

// [acg_pkg.sv]
// Types for the channel gate control
// Assumes nothing beyond the defines header
package acg_pkg;
    typedef enum logic [0:0] {ACG_IDLE, ACG_PASS} acg_state_t;
endpackage

// [acg_ctrl.sv]
// Channel skip mask, single pass trigger and deep shutdown control
// Assumes run bit, mode and sequencer signals come from logic on clk
`timescale 1ns/10ps
`include "acg_defines.svh"

module acg_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic run_bit,
    input wire logic [1:0] input_mode,
    input wire logic pass_done,
    input wire logic [2:0] seq_chan,
    input wire logic seq_result_wr,
    input wire logic [7:0] limit_err,
    input wire logic [2:0] reading_sel,
    input wire logic [11:0] reading_raw,
    output logic [11:0] reading_out,
    output logic [7:0] skip_mask,
    output logic result_wr_en,
    output logic [7:0] err_event,
    output logic pass_start,
    output logic pass_active,
    output logic deep_shutdown,
    output logic clear_results
);
    // Writable disable bits per input mode
    function automatic logic [7:0] wmask(input logic [1:0] m);
        case (m)
            `ACG_MODE_2: wmask = `ACG_WMASK_M2;
            `ACG_MODE_3: wmask = `ACG_WMASK_M3;
            default: wmask = `ACG_WMASK_FULL;
        endcase
    endfunction

    acg_pkg::acg_state_t state_q, state_d;
    logic [7:0] skip_q, skip_d;
    logic deep_q, deep_d;
    logic was_deep_q, was_deep_d;
    logic [7:0] rdata_d;
    logic [11:0] reading_d;
    logic wr_skip, wr_trig, wr_deep, trig_go;

    assign wr_skip = reg_wr && (reg_addr == `ACG_ADDR_SKIP);
    assign wr_trig = reg_wr && (reg_addr == `ACG_ADDR_TRIG);
    assign wr_deep = reg_wr && (reg_addr == `ACG_ADDR_DEEP);
    assign trig_go = wr_trig && reg_wdata[`ACG_TRIG_BIT] && !run_bit
        && (state_q == acg_pkg::ACG_IDLE);

    assign skip_mask = skip_q & wmask(input_mode);
    assign result_wr_en = seq_result_wr && !skip_mask[seq_chan];
    assign err_event = limit_err & ~skip_mask;
    assign clear_results = wr_skip;
    assign pass_start = trig_go;
    assign pass_active = (state_q == acg_pkg::ACG_PASS);
    assign deep_shutdown = deep_q && !run_bit && !pass_active;

    always_comb
    begin
        state_d = state_q;
        skip_d = skip_q;
        deep_d = deep_q;
        was_deep_d = was_deep_q;
        rdata_d = 8'h00;
        if (wr_skip)
            skip_d = reg_wdata & wmask(input_mode);
        if (wr_deep)
            deep_d = reg_wdata[`ACG_DEEP_BIT];
        case (state_q)
            acg_pkg::ACG_IDLE:
            begin
                if (trig_go)
                begin
                    state_d = acg_pkg::ACG_PASS;
                    was_deep_d = deep_shutdown;
                end
            end
            acg_pkg::ACG_PASS:
            begin
                if (pass_done)
                    state_d = acg_pkg::ACG_IDLE;
            end
            default: state_d = acg_pkg::ACG_IDLE;
        endcase
        if (reg_rd)
        begin
            case (reg_addr)
                `ACG_ADDR_SKIP: rdata_d = skip_mask;
                `ACG_ADDR_DEEP: rdata_d = {7'h00, deep_q};
                default: rdata_d = 8'h00;
            endcase
        end
        reading_d = skip_mask[reading_sel] ? 12'h000 : reading_raw;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= acg_pkg::ACG_IDLE;
            skip_q <= `ACG_SKIP_RESET;
            deep_q <= `ACG_DEEP_RESET;
            was_deep_q <= 1'b0;
            reg_rdata <= 8'h00;
            reading_out <= 12'h000;
        end
        else
        begin
            state_q <= state_d;
            skip_q <= skip_d;
            deep_q <= deep_d;
            was_deep_q <= was_deep_d;
            reg_rdata <= rdata_d;
            reading_out <= reading_d;
        end
    end

    a_skip_reads_zero: assert property (@(posedge clk) disable iff (!resetn)
        skip_mask[reading_sel] |=> (reading_out == 12'h000))
        else $error("Disabled channel reading not zero");
    a_skip_no_write: assert property (@(posedge clk) disable iff (!resetn)
        (seq_result_wr && skip_mask[seq_chan]) |-> !result_wr_en)
        else $error("Disabled channel result written");
    a_skip_no_error: assert property (@(posedge clk) disable iff (!resetn)
        (err_event & skip_mask) == 8'h00)
        else $error("Error event on disabled channel");
    a_mode2_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (input_mode == `ACG_MODE_2) |-> (skip_mask[6:4] == 3'h0))
        else $error("Mode 2 reserved bits set");
    a_mode3_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == `ACG_ADDR_SKIP && input_mode == `ACG_MODE_3)
        |=> !reg_rdata[6])
        else $error("Mode 3 reserved bit reads one");
    a_mode01_full: assert property (@(posedge clk) disable iff (!resetn)
        (wr_skip && !input_mode[1]) ##1 !wr_skip && !input_mode[1]
        |-> (skip_mask == $past(reg_wdata)))
        else $error("Mode 0/1 mask not fully writable");
    a_trig_one_pass: assert property (@(posedge clk) disable iff (!resetn)
        (wr_trig && reg_wdata[0] && !run_bit && !pass_active)
        |-> pass_start ##1 (pass_active && !pass_start))
        else $error("Trigger did not start one pass");
    a_trig_reads_zero: assert property (@(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == `ACG_ADDR_TRIG) |=> (reg_rdata == 8'h00))
        else $error("Trigger register not write-only");
    a_pass_returns: assert property (@(posedge clk) disable iff (!resetn)
        (pass_active && pass_done && !wr_deep && (deep_q == was_deep_q))
        |=> (!pass_active && (deep_shutdown == (was_deep_q && !run_bit))))
        else $error("Pass did not return to prior state");
    a_deep_needs_stop: assert property (@(posedge clk) disable iff (!resetn)
        deep_shutdown |-> (!run_bit && deep_q))
        else $error("Deep shutdown while running");
    a_mask_clears: assert property (@(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr == `ACG_ADDR_SKIP) |-> clear_results)
        else $error("Mask write did not clear results");

    // Refused triggers
    a_trig_run_refused: assert property (@(posedge clk) disable iff (!resetn)
        (wr_trig && run_bit) |-> !pass_start)
        else $error("Trigger accepted while running");
    a_trig_busy_refused: assert property (@(posedge clk) disable iff (!resetn)
        (wr_trig && pass_active) |-> !pass_start)
        else $error("Trigger accepted during a pass");
    a_trig_bit_clear: assert property (@(posedge clk) disable iff (!resetn)
        (wr_trig && !reg_wdata[`ACG_TRIG_BIT]) |-> !pass_start)
        else $error("Trigger accepted with bit clear");

    // Pass lifetime
    a_pass_holds: assert property (@(posedge clk) disable iff (!resetn)
        (pass_active && !pass_done) |=> pass_active)
        else $error("Pass ended without done");
    a_pass_ends: assert property (@(posedge clk) disable iff (!resetn)
        (pass_active && pass_done) |=> !pass_active)
        else $error("Pass ran past done");

    // Deep shutdown entry and exit, and deep register reserved bits
    a_deep_enters: assert property (@(posedge clk) disable iff (!resetn)
        (wr_deep && reg_wdata[`ACG_DEEP_BIT]) ##1 (!run_bit && !pass_active)
        |-> deep_shutdown)
        else $error("Deep shutdown not entered");
    a_deep_leaves: assert property (@(posedge clk) disable iff (!resetn)
        (wr_deep && !reg_wdata[`ACG_DEEP_BIT]) |=> !deep_shutdown)
        else $error("Deep shutdown not left");
    a_deep_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == `ACG_ADDR_DEEP) |=> (reg_rdata[7:1] == 7'h00))
        else $error("Deep register reserved bits read one");

    // Enabled channels pass through
    a_result_passes: assert property (@(posedge clk) disable iff (!resetn)
        (seq_result_wr && !skip_mask[seq_chan]) |-> result_wr_en)
        else $error("Enabled channel result dropped");
    a_reading_passes: assert property (@(posedge clk) disable iff (!resetn)
        !skip_mask[reading_sel] |=> (reading_out == $past(reading_raw)))
        else $error("Enabled channel reading altered");
    a_error_passes: assert property (@(posedge clk) disable iff (!resetn)
        ((limit_err & ~skip_mask & ~err_event) == 8'h00))
        else $error("Error event on enabled channel lost");

    // Mode 2 and 3 writable bits, and no result clear on writes to other registers
    a_mode2_bits: assert property (@(posedge clk) disable iff (!resetn)
        (wr_skip && input_mode == `ACG_MODE_2) ##1 (!wr_skip && input_mode == `ACG_MODE_2)
        |-> (skip_mask == ($past(reg_wdata) & 8'h8F)))
        else $error("Mode 2 mask bits wrong");
    a_mode3_bits: assert property (@(posedge clk) disable iff (!resetn)
        (wr_skip && input_mode == `ACG_MODE_3) ##1 (!wr_skip && input_mode == `ACG_MODE_3)
        |-> (skip_mask == ($past(reg_wdata) & 8'hBF)))
        else $error("Mode 3 mask bits wrong");
    a_mask_other_write: assert property (@(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr != `ACG_ADDR_SKIP) |-> !clear_results)
        else $error("Results cleared by another write");
endmodule

// [acg_seq_model.sv]
// Sequencer stand-in that ends a single pass after a set delay
// Assumes pass_active comes from the control block on the same clock
`timescale 1ns/10ps
module acg_seq_model (
    input wire logic clk,
    input wire logic pass_active,
    input wire logic [3:0] delay,
    output logic pass_done
);
    int cnt = 0;
    initial pass_done = 1'b0;
    always @(posedge clk)
    begin
        pass_done <= 1'b0;
        cnt <= pass_active ? cnt + 1 : 0;
        if (pass_active && cnt == delay)
            pass_done <= 1'b1;
    end
endmodule

// [tb_acg_ctrl.sv]
// Bench for the channel gate control
// Assumes the sequencer stand-in ends each single pass
`timescale 1ns/10ps
`include "acg_defines.svh"
module tb_acg_ctrl;
    logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, run_bit = 0, seq_result_wr = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, limit_err = 0, reg_rdata, skip_mask, err_event, v;
    logic [1:0] input_mode = 0;
    logic [2:0] seq_chan = 0, reading_sel = 0;
    logic [3:0] dly = 0;
    logic [11:0] reading_raw = 0, reading_out;
    logic pass_done, result_wr_en, pass_start, pass_active, deep_shutdown, clear_results;
    logic ps = 0, cr = 0, rd_d1 = 0;
    logic [7:0] wm [4] = '{`ACG_WMASK_FULL, `ACG_WMASK_FULL, `ACG_WMASK_M2, `ACG_WMASK_M3};
    logic [7:0] exp_q [$];
    int miscompares = 0, check_count = 0, i, k;
    always #10 clk = ~clk;
    acg_ctrl dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .run_bit,
        .input_mode, .pass_done, .seq_chan, .seq_result_wr, .limit_err, .reading_sel,
        .reading_raw, .reading_out, .skip_mask, .result_wr_en, .err_event, .pass_start,
        .pass_active, .deep_shutdown, .clear_results);
    acg_seq_model seq (.clk, .pass_active, .delay(dly), .pass_done);
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        #2;
        ps = pass_start;
        cr = clear_results;
        tick();
        reg_wr = 0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1;
        exp_q.push_back(e);
        tick();
        reg_rd = 0;
        tick();
    endtask
    // Read data watcher
    always @(posedge clk)
    begin
        if (rd_d1)
            chk(12'(reg_rdata), 12'(exp_q.pop_front()));
        rd_d1 <= reg_rd;
    end
    initial
    begin
        v = 8'($urandom(43232));
        repeat (20) @(posedge clk);
        #1;
        resetn = 1;
        tick();
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h0A, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            input_mode = i[1:0];
            v = 8'($urandom);
            wr(8'h08, v);
            chk(12'(cr), 12'h1);
            v = v & wm[i];
            rd(8'h08, v);
            limit_err = 8'($urandom);
            seq_chan = 3'($urandom);
            reading_sel = seq_chan;
            reading_raw = 12'($urandom);
            seq_result_wr = 1;
            tick();
            chk(12'(skip_mask), 12'(v));
            chk(12'(err_event), 12'(limit_err & ~v));
            chk(12'(result_wr_en), 12'(!v[seq_chan]));
            chk(reading_out, v[reading_sel] ? 12'h0 : reading_raw);
            seq_result_wr = 0;
        end
        run_bit = 1;
        wr(8'h0A, 8'h01);
        chk(12'(deep_shutdown), 12'h0);
        chk(12'(cr), 12'h0);
        wr(8'h09, 8'h01);
        chk(12'(ps), 12'h0);
        run_bit = 0;
        tick();
        chk(12'(deep_shutdown), 12'h1);
        rd(8'h0A, 8'h01);
        wr(8'h09, 8'hFE);
        chk(12'(ps), 12'h0);
        chk(12'(pass_active), 12'h0);
        for (i = 0; i < 2; i++)
        begin
            dly = i[0] ? 4'h7 : 4'h0;
            wr(8'h0A, {7'h0, i[0]});
            wr(8'h09, 8'h01);
            chk(12'(ps), 12'h1);
            wr(8'h09, 8'h01);
            chk(12'(ps), 12'h0);
            for (k = 0; k < 40 && pass_active; k++)
            begin
                chk(12'(deep_shutdown), 12'h0);
                tick();
            end
            if (k == 40)
            begin
                miscompares++;
                end_sim();
            end
            repeat (3) tick();
            chk(12'(pass_active), 12'h0);
            chk(12'(deep_shutdown), 12'(i[0]));
        end
        end_sim();
    end
endmodule
